// File: tb/rcoc_emitter_model.sv
// emitter driver model: records pulse activity seen on the remote output pin
`timescale 1ns/1ns
`default_nettype none

module rcoc_emitter_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // remote output pin
  input  wire logic        drive,
  // observed activity
  output logic      [15:0] pulse_cnt,
  output logic      [15:0] max_run
);
  logic [15:0] run_ff;

  // count rising edges and the longest stretch the emitter stays lit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_ff    <= 16'h0000;
      pulse_cnt <= 16'h0000;
      max_run   <= 16'h0000;
    end
    else if (drive === 1'b1)
    begin
      run_ff <= run_ff + 16'h0001;
      if (run_ff == 16'h0000) pulse_cnt <= pulse_cnt + 16'h0001;
      if (run_ff + 16'h0001 > max_run) max_run <= run_ff + 16'h0001;
    end
    else
      run_ff <= 16'h0000;
  end
endmodule : rcoc_emitter_model
`default_nettype wire

// File: tb/rcoc_top_tb.sv
// testbench: register accesses, waveform timing, routing and interrupt of the remote block
`timescale 1ns/1ns
`default_nettype none

module rcoc_top_tb;
  logic        core_clk, rst_n, reg_wr, reg_rd, shared_pin_in, segment_drive;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pulse_cnt, max_run;
  logic [3:0]  timer_out_pins;
  logic        remote_output_pin, shared_pin_out, shared_pin_oe, irq;
  int          fail_count = 0;
  int          checks = 0;

  rcoc_top #(.CNT_W(16)) uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_out_pins(timer_out_pins), .remote_output_pin(remote_output_pin),
    .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .segment_drive(segment_drive), .irq(irq));

  rcoc_emitter_model emit (.core_clk(core_clk), .rst_n(rst_n), .drive(remote_output_pin),
    .pulse_cnt(pulse_cnt), .max_run(max_run));

  // 100 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // n clocks later, settled
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rd

  // length of the next high stretch on one timer pin
  task automatic meas(input int i, input logic [15:0] e);
    int n;
    n = 0;
    while (timer_out_pins[i] !== 1'b0 && n < 400) begin cyc(1); n++; end
    while (timer_out_pins[i] !== 1'b1 && n < 400) begin cyc(1); n++; end
    n = 0;
    while (timer_out_pins[i] === 1'b1 && n < 400) begin cyc(1); n++; end
    chk("high_run", e, 16'(n));
  endtask : meas

  task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // watchdog
  initial
  begin
    #3000000;
    fail_count++;
    final_report();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00; reg_wdata = 16'h0000;
    shared_pin_in = 1'b0; segment_drive = 1'b1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(1);
    chk("pin_oe", 16'h0000, {15'h0, shared_pin_oe});
    rd("port_dir", 5'h0E, 16'h00FF);
    rd("unmapped", 5'h11, 16'h0000);
    // shared pin routing
    wr(5'h0C, 16'h0010); cyc(1);
    chk("seg_out", 16'h0003, {14'h0, shared_pin_oe, shared_pin_out});
    wr(5'h0C, 16'h0000); wr(5'h0D, 16'h0001); cyc(1);
    chk("port_off", 16'h0001, {14'h0, shared_pin_oe, shared_pin_out});
    rd("latch_pin", 5'h0D, 16'h0000);
    wr(5'h0E, 16'h00FE); cyc(1);
    chk("port_on", 16'h0003, {14'h0, shared_pin_oe, shared_pin_out});
    // frozen output written by software, then polarity
    wr(5'h06, 16'h0008); rd("out_val", 5'h06, 16'h0008);
    cyc(3);
    chk("pin_pos", 16'h0002, {12'h0, timer_out_pins});
    wr(5'h05, 16'h0008); cyc(3);
    chk("pin_neg", 16'h0000, {12'h0, timer_out_pins});
    wr(5'h05, 16'h0000); wr(5'h06, 16'h0000);
    // carrier and mask setup, software side
    // carrier uses the documented figures so the width assertion is exercised
    wr(5'h01, 16'h00C7); wr(5'h00, 16'h003C);
    wr(5'h02, 16'h0063); wr(5'h03, 16'h0032);
    wr(5'h04, 16'h0028); wr(5'h07, 16'h003C);
    wr(5'h06, 16'h0020); rd("out_val_ign", 5'h06, 16'h0000);
    wr(5'h08, 16'h0000); rd("run_none", 5'h0A, 16'h0000);
    wr(5'h08, 16'h003C); rd("run_all", 5'h0A, 16'h003C);
    rd("start_rd", 5'h08, 16'h0000);
    meas(3, 16'h003C);
    meas(2, 16'h00C8);
    meas(1, 16'h0032);
    meas(0, 16'h0064);
    // combined remote output
    // stop lands clear of a carrier high width so no width check is cut short
    wr(5'h0B, 16'h0001); cyc(400);
    chk("plain_pins", 16'h0000, {12'h0, timer_out_pins});
    chk("emit_run", 16'h0032, max_run);
    chk("emit_seen", 16'h0001, {15'h0, pulse_cnt != 16'h0000});
    // stop, then interrupt status and mask
    wr(5'h09, 16'h0000); rd("run_kept", 5'h0A, 16'h003C);
    wr(5'h09, 16'h003C); rd("run_off", 5'h0A, 16'h0000);
    cyc(20);
    rd("irq_stat", 5'h0F, 16'h000F);
    chk("irq_masked", 16'h0000, {15'h0, irq});
    wr(5'h10, 16'h0008); cyc(1);
    chk("irq_on", 16'h0001, {15'h0, irq});
    wr(5'h0F, 16'h0008); cyc(1);
    chk("irq_clr", 16'h0000, {15'h0, irq});
    rd("irq_left", 5'h0F, 16'h0007);
    final_report();
  end
endmodule : rcoc_top_tb
`default_nettype wire

// File: verilog/rcoc_pkg.sv
// package: register map, field positions, reset values and timing for the remote output block
package rcoc_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_CARRIER_HIGH  = 4'h0;
  localparam logic [3:0] ADDR_CARRIER_PER   = 4'h1;
  localparam logic [3:0] ADDR_MASK_PER      = 4'h2;
  localparam logic [3:0] ADDR_MASK_HIGH     = 4'h3;
  localparam logic [3:0] ADDR_OUT_MODE      = 4'h4;
  localparam logic [3:0] ADDR_OUT_POL       = 4'h5;
  localparam logic [3:0] ADDR_OUT_VAL       = 4'h6;
  localparam logic [3:0] ADDR_OUT_EN        = 4'h7;
  localparam logic [3:0] ADDR_START         = 4'h8;
  localparam logic [3:0] ADDR_STOP          = 4'h9;
  localparam logic [3:0] ADDR_RUN_STATUS    = 4'hA;
  localparam logic [3:0] ADDR_REMOTE_SEL    = 4'hB;
  localparam logic [3:0] ADDR_SEG_FUNC      = 4'hC;
  localparam logic [3:0] ADDR_PORT_LATCH    = 4'hD;
  localparam logic [3:0] ADDR_PORT_DIR      = 4'hE;
  localparam logic [3:0] ADDR_IRQ_STATUS    = 4'hF;
  localparam logic [3:0] ADDR_IRQ_MASK      = 4'h0; // second page, see ADDR_PAGE_BIT
  localparam int         ADDR_W             = 5;
  localparam int         ADDR_PAGE_BIT      = 4;

  // channel numbers
  localparam int CH_MASK_MASTER    = 2;
  localparam int CH_MASK_SLAVE     = 3;
  localparam int CH_CARRIER_MASTER = 4;
  localparam int CH_CARRIER_SLAVE  = 5;
  localparam int CH_LO             = 2;
  localparam int CH_HI             = 5;
  localparam int NUM_CH            = 8;

  // field positions
  localparam int SEG_SHARED_BIT  = 4;
  localparam int PORT_SHARED_BIT = 0;
  localparam int REMOTE_SEL_BIT  = 0;

  // reset values
  localparam logic [15:0] RST_DATA     = 16'h0000;
  localparam logic [15:0] RST_CH_BITS  = 16'h0000;
  localparam logic [7:0]  RST_SEG      = 8'h00;
  localparam logic [7:0]  RST_LATCH    = 8'h00;
  localparam logic [7:0]  RST_DIR      = 8'hFF;

  // documented example figures in count clocks
  localparam logic [15:0] EX_CARRIER_HIGH = 16'h003C; // 60 -> 7.5 us at 8 MHz
  localparam logic [15:0] EX_CARRIER_PER  = 16'h00C7; // 199 -> 25 us at 8 MHz

  // interrupt status bits
  typedef struct packed {
    logic carrier_slave;
    logic carrier_master;
    logic mask_slave;
    logic mask_master;
  } rcoc_irq_s;

  // per-channel timer events
  typedef struct packed {
    logic [NUM_CH-1:0] tick;
  } rcoc_evt_s;

endpackage : rcoc_pkg

// File: verilog/rcoc_top.sv
// remote control output block: carrier and mask channels, output control, pin routing
//
// Operation
// - the carrier slave output stays active for as many count clocks as its data value.
// - output-mode bit 0 toggles a channel output on each of its own interrupts.
// - output-mode bit 1 sets the output on the master interrupt and resets it on the slave's.
// - the polarity bit at 0 drives the pin high when active, at 1 low when active.
// - each output-value bit holds the current output level, 0 low and 1 high.
// - with output enable 0 the output is frozen and software writes to its value bit apply.
// - with output enable 1 the timer drives the value bit and software writes to it are ignored.
// - segment-function bit 4 gives the shared pin to the port at 0 and to segment output at 1.
// - port direction bit 0 turns the output buffer on, 1 turns it off; the latch sets the level.
// - writing 1 to a start bit sets the channel's run flag and starts counting; 0 does nothing.
// - remote select 1 routes the combined output to the remote pin; 0 gives plain outputs.
// - a master channel repeats its period every data value plus one count clocks.
// - writing 1 to a stop bit stops the channel; 0 does nothing.
`timescale 1ns/1ns
`default_nettype none

module rcoc_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // register port
  input  wire logic [4:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // timer output pins of channels 2 to 5
  output logic      [3:0]       timer_out_pins,
  // dedicated remote output pin
  output logic                  remote_output_pin,
  // shared pin, three signals
  input  wire logic             shared_pin_in,
  output logic                  shared_pin_out,
  output logic                  shared_pin_oe,
  // segment output driving the shared pin in segment mode
  input  wire logic             segment_drive,
  // interrupt
  output logic                  irq
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  if (CNT_W < 8 || CNT_W > 16)
  begin : g_bad_width
    $error("rcoc_top: CNT_W must be 8 to 16");
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [15:0] carrier_high_width_data_ff;
  logic [15:0] carrier_period_data_ff;
  logic [15:0] mask_period_data_ff;
  logic [15:0] mask_high_width_data_ff;
  logic [15:0] output_mode_select_ff;
  logic [15:0] output_polarity_select_ff;
  logic [15:0] output_level_value_ff;
  logic [15:0] output_enable_control_ff;
  logic [15:0] channel_operation_enable_ff;
  logic        remote_output_select_ff;
  logic [7:0]  segment_function_select_b_ff;
  logic [7:0]  port_three_latch_ff;
  logic [7:0]  port_three_direction_ff;
  rcoc_pkg::rcoc_irq_s irq_status_ff;
  rcoc_pkg::rcoc_irq_s irq_mask_ff;

  logic        page_hi;
  logic [3:0]  idx;
  logic        wr_lo;
  logic        wr_hi;
  rcoc_pkg::rcoc_evt_s evt;

  assign page_hi = reg_addr[rcoc_pkg::ADDR_PAGE_BIT];
  assign idx     = reg_addr[3:0];
  assign wr_lo   = reg_wr && !page_hi;
  assign wr_hi   = reg_wr && page_hi;

  // data and configuration registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier_high_width_data_ff   <= rcoc_pkg::RST_DATA;
      carrier_period_data_ff       <= rcoc_pkg::RST_DATA;
      mask_period_data_ff          <= rcoc_pkg::RST_DATA;
      mask_high_width_data_ff      <= rcoc_pkg::RST_DATA;
      output_mode_select_ff        <= rcoc_pkg::RST_CH_BITS;
      output_polarity_select_ff    <= rcoc_pkg::RST_CH_BITS;
      output_enable_control_ff     <= rcoc_pkg::RST_CH_BITS;
      remote_output_select_ff      <= 1'b0;
      segment_function_select_b_ff <= rcoc_pkg::RST_SEG;
      port_three_latch_ff          <= rcoc_pkg::RST_LATCH;
      port_three_direction_ff      <= rcoc_pkg::RST_DIR;
      irq_mask_ff                  <= '0;
    end
    else if (wr_lo)
    begin
      case (idx)
        rcoc_pkg::ADDR_CARRIER_HIGH: carrier_high_width_data_ff <= reg_wdata;
        rcoc_pkg::ADDR_CARRIER_PER:  carrier_period_data_ff     <= reg_wdata;
        rcoc_pkg::ADDR_MASK_PER:     mask_period_data_ff        <= reg_wdata;
        rcoc_pkg::ADDR_MASK_HIGH:    mask_high_width_data_ff    <= reg_wdata;
        rcoc_pkg::ADDR_OUT_MODE:     output_mode_select_ff      <= {8'h00, reg_wdata[7:1], 1'b0};
        rcoc_pkg::ADDR_OUT_POL:      output_polarity_select_ff  <= {8'h00, reg_wdata[7:1], 1'b0};
        rcoc_pkg::ADDR_OUT_EN:       output_enable_control_ff   <= {8'h00, reg_wdata[7:0]};
        rcoc_pkg::ADDR_REMOTE_SEL:   remote_output_select_ff    <= reg_wdata[rcoc_pkg::REMOTE_SEL_BIT];
        rcoc_pkg::ADDR_SEG_FUNC:     segment_function_select_b_ff <= reg_wdata[7:0];
        rcoc_pkg::ADDR_PORT_LATCH:   port_three_latch_ff        <= {2'b00, reg_wdata[5:0]};
        rcoc_pkg::ADDR_PORT_DIR:     port_three_direction_ff    <= {2'b11, reg_wdata[5:0]};
        default: ;
      endcase
    end
    else if (wr_hi && idx == rcoc_pkg::ADDR_IRQ_MASK)
    begin
      irq_mask_ff <= reg_wdata[3:0];
    end
  end

  // ------------------------------------------------------------------
  // run flags: start sets, stop clears
  // ------------------------------------------------------------------
  logic [15:0] start_pulse;
  logic [15:0] stop_pulse;
  assign start_pulse = (wr_lo && idx == rcoc_pkg::ADDR_START) ? {8'h00, reg_wdata[7:0]} : 16'h0000;
  assign stop_pulse  = (wr_lo && idx == rcoc_pkg::ADDR_STOP)  ? {8'h00, reg_wdata[7:0]} : 16'h0000;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      channel_operation_enable_ff <= rcoc_pkg::RST_CH_BITS;
    else
      channel_operation_enable_ff <= (channel_operation_enable_ff & ~stop_pulse)
                                     | start_pulse;
  end

  // ------------------------------------------------------------------
  // counters: masters reload on period, slaves one-count on master tick
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff [rcoc_pkg::CH_LO:rcoc_pkg::CH_HI];
  logic [rcoc_pkg::CH_HI:rcoc_pkg::CH_LO] busy_ff;
  logic [rcoc_pkg::CH_HI:rcoc_pkg::CH_LO] run;
  assign run = channel_operation_enable_ff[rcoc_pkg::CH_HI:rcoc_pkg::CH_LO];

  // master channels 2 and 4 count down from data and wrap: period = data + 1
  for (genvar m = rcoc_pkg::CH_LO; m <= rcoc_pkg::CH_CARRIER_MASTER; m += 2)
  begin : g_master
    logic [CNT_W-1:0] per;
    logic             first_ff;
    assign per = (m == rcoc_pkg::CH_MASK_MASTER) ? mask_period_data_ff[CNT_W-1:0]
                                                 : carrier_period_data_ff[CNT_W-1:0];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_ff[m]   <= '0;
        first_ff    <= 1'b0;
        busy_ff[m]  <= 1'b0;
      end
      else if (!run[m] || start_pulse[m])
      begin
        cnt_ff[m]   <= per;
        first_ff    <= start_pulse[m];
        busy_ff[m]  <= start_pulse[m];
      end
      else
      begin
        first_ff <= 1'b0;
        cnt_ff[m] <= (cnt_ff[m] == '0) ? per : cnt_ff[m] - 1'b1;
      end
    end
    // tick on start and whenever the count wraps
    assign evt.tick[m] = run[m] && (first_ff || (busy_ff[m] && !start_pulse[m] && cnt_ff[m] == '0));
  end

  // slave channels 3 and 5 load data on master tick and tick when they reach zero
  for (genvar s = rcoc_pkg::CH_MASK_SLAVE; s <= rcoc_pkg::CH_HI; s += 2)
  begin : g_slave
    logic [CNT_W-1:0] wid;
    assign wid = (s == rcoc_pkg::CH_MASK_SLAVE) ? mask_high_width_data_ff[CNT_W-1:0]
                                                : carrier_high_width_data_ff[CNT_W-1:0];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_ff[s]  <= '0;
        busy_ff[s] <= 1'b0;
      end
      else if (!run[s])
        busy_ff[s] <= 1'b0;
      else if (evt.tick[s-1] && wid != '0)
      begin
        cnt_ff[s]  <= wid - 1'b1;
        busy_ff[s] <= 1'b1;
      end
      else if (busy_ff[s])
      begin
        cnt_ff[s]  <= cnt_ff[s] - 1'b1;
        busy_ff[s] <= (cnt_ff[s] != '0);
      end
    end
    // slave end of high width, zero width ticks in the same cycle as the master tick, where the master set wins
    assign evt.tick[s] = run[s] && ((busy_ff[s] && cnt_ff[s] == '0 && !evt.tick[s-1])
                                    || (evt.tick[s-1] && wid == '0));
  end

  assign evt.tick[1:0] = 2'b00;
  assign evt.tick[7:6] = 2'b00;

  // ------------------------------------------------------------------
  // output value bits: timer when enabled, software when not
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      output_level_value_ff <= rcoc_pkg::RST_CH_BITS;
    else
    begin
      for (int c = 0; c < rcoc_pkg::NUM_CH; c++)
      begin
        if (output_enable_control_ff[c])
        begin
          if (output_mode_select_ff[c] && c > 0)
          begin
            if (evt.tick[c-1] && c[0])
              output_level_value_ff[c] <= 1'b1;
            else if (evt.tick[c])
              output_level_value_ff[c] <= 1'b0;
          end
          else if (evt.tick[c])
            output_level_value_ff[c] <= ~output_level_value_ff[c];
        end
        else if (wr_lo && idx == rcoc_pkg::ADDR_OUT_VAL)
          output_level_value_ff[c] <= reg_wdata[c];
      end
    end
  end

  // ------------------------------------------------------------------
  // pins: polarity, remote gating, shared pin routing
  // ------------------------------------------------------------------
  logic [3:0] lvl;
  logic       remote_comb;
  assign lvl = output_level_value_ff[rcoc_pkg::CH_HI:rcoc_pkg::CH_LO]
             ^ output_polarity_select_ff[rcoc_pkg::CH_HI:rcoc_pkg::CH_LO];
  assign remote_comb = lvl[rcoc_pkg::CH_CARRIER_SLAVE-rcoc_pkg::CH_LO]
                     & lvl[rcoc_pkg::CH_MASK_SLAVE-rcoc_pkg::CH_LO];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_out_pins    <= 4'h0;
      remote_output_pin <= 1'b0;
    end
    else
    begin
      timer_out_pins    <= remote_output_select_ff ? 4'h0 : lvl;
      remote_output_pin <= remote_output_select_ff & remote_comb;
    end
  end

  // shared pin: segment output or port latch, buffer on when direction bit is 0
  assign shared_pin_out = segment_function_select_b_ff[rcoc_pkg::SEG_SHARED_BIT]
                        ? segment_drive : port_three_latch_ff[rcoc_pkg::PORT_SHARED_BIT];
  assign shared_pin_oe  = segment_function_select_b_ff[rcoc_pkg::SEG_SHARED_BIT]
                        | ~port_three_direction_ff[rcoc_pkg::PORT_SHARED_BIT];

  // ------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ------------------------------------------------------------------
  rcoc_pkg::rcoc_irq_s irq_set;
  rcoc_pkg::rcoc_irq_s irq_clr;
  assign irq_set = evt.tick[rcoc_pkg::CH_HI:rcoc_pkg::CH_LO];
  assign irq_clr = (wr_lo && idx == rcoc_pkg::ADDR_IRQ_STATUS) ? reg_wdata[3:0] : 4'h0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_ff <= '0;
    else
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_status_ff & irq_mask_ff);

  // ------------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ------------------------------------------------------------------
  logic [15:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (page_hi)
      nxt_rdata = (idx == rcoc_pkg::ADDR_IRQ_MASK) ? {12'h000, irq_mask_ff} : 16'h0000;
    else
    begin
      case (idx)
        rcoc_pkg::ADDR_CARRIER_HIGH: nxt_rdata = carrier_high_width_data_ff;
        rcoc_pkg::ADDR_CARRIER_PER:  nxt_rdata = carrier_period_data_ff;
        rcoc_pkg::ADDR_MASK_PER:     nxt_rdata = mask_period_data_ff;
        rcoc_pkg::ADDR_MASK_HIGH:    nxt_rdata = mask_high_width_data_ff;
        rcoc_pkg::ADDR_OUT_MODE:     nxt_rdata = output_mode_select_ff;
        rcoc_pkg::ADDR_OUT_POL:      nxt_rdata = output_polarity_select_ff;
        rcoc_pkg::ADDR_OUT_VAL:      nxt_rdata = output_level_value_ff;
        rcoc_pkg::ADDR_OUT_EN:       nxt_rdata = output_enable_control_ff;
        rcoc_pkg::ADDR_RUN_STATUS:   nxt_rdata = channel_operation_enable_ff;
        rcoc_pkg::ADDR_REMOTE_SEL:   nxt_rdata = {15'h0000, remote_output_select_ff};
        rcoc_pkg::ADDR_SEG_FUNC:     nxt_rdata = {8'h00, segment_function_select_b_ff};
        rcoc_pkg::ADDR_PORT_LATCH:   nxt_rdata = {8'h00, port_three_latch_ff[7:1], shared_pin_in};
        rcoc_pkg::ADDR_PORT_DIR:     nxt_rdata = {8'h00, port_three_direction_ff};
        rcoc_pkg::ADDR_IRQ_STATUS:   nxt_rdata = {12'h000, irq_status_ff};
        default:                     nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? nxt_rdata : 16'h0000;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_start_sets_run;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_lo && idx == rcoc_pkg::ADDR_START && reg_wdata[5]) |=> channel_operation_enable_ff[5];
  endproperty
  a_start_sets_run: assert property (p_start_sets_run) else $error("start did not set run flag");

  property p_start_zero_noop;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_lo && idx == rcoc_pkg::ADDR_START && !reg_wdata[5] && !stop_pulse[5])
      |=> channel_operation_enable_ff[5] == $past(channel_operation_enable_ff[5]);
  endproperty
  a_start_zero_noop: assert property (p_start_zero_noop) else $error("zero start changed run flag");

  property p_stop_clears_run;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_lo && idx == rcoc_pkg::ADDR_STOP && reg_wdata[4]) |=> !channel_operation_enable_ff[4];
  endproperty
  a_stop_clears_run: assert property (p_stop_clears_run) else $error("stop did not clear run flag");

  property p_frozen_when_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    (!output_enable_control_ff[5] && !(wr_lo && idx == rcoc_pkg::ADDR_OUT_VAL))
      |=> $stable(output_level_value_ff[5]);
  endproperty
  a_frozen_when_disabled: assert property (p_frozen_when_disabled) else $error("disabled output moved");

  property p_sw_write_ignored;
    @(posedge core_clk) disable iff (!rst_n)
    (output_enable_control_ff[5] && wr_lo && idx == rcoc_pkg::ADDR_OUT_VAL && !evt.tick[4] && !evt.tick[5])
      |=> $stable(output_level_value_ff[5]);
  endproperty
  a_sw_write_ignored: assert property (p_sw_write_ignored) else $error("enabled output took write");

  property p_slave_set;
    @(posedge core_clk) disable iff (!rst_n)
    (output_enable_control_ff[5] && output_mode_select_ff[5] && evt.tick[4]) |=> output_level_value_ff[5];
  endproperty
  a_slave_set: assert property (p_slave_set) else $error("slave output not set by master");

  property p_carrier_width;
    @(posedge core_clk) disable iff (!rst_n)
    (evt.tick[4] && run[5] && carrier_high_width_data_ff == rcoc_pkg::EX_CARRIER_HIGH
      && carrier_period_data_ff == rcoc_pkg::EX_CARRIER_PER) |-> ##60 evt.tick[5];
  endproperty
  a_carrier_width: assert property (p_carrier_width) else $error("carrier width not 60 clocks");

  property p_master_toggle;
    @(posedge core_clk) disable iff (!rst_n)
    (output_enable_control_ff[2] && !output_mode_select_ff[2] && evt.tick[2])
      |=> output_level_value_ff[2] != $past(output_level_value_ff[2]);
  endproperty
  a_master_toggle: assert property (p_master_toggle) else $error("master output did not toggle");

  property p_remote_gate;
    @(posedge core_clk) disable iff (!rst_n)
    remote_output_select_ff |=> remote_output_pin == $past(remote_comb) && timer_out_pins == 4'h0;
  endproperty
  a_remote_gate: assert property (p_remote_gate) else $error("remote routing wrong");

endmodule : rcoc_top

`default_nettype wire
